// ---- logic/itp_timing.sv ----
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module itp_timing (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire itp_pkg::itp_bus_req_t bus_req,
  output logic [31:0] rd_data,
  input wire logic boot_active,
  input wire itp_pkg::itp_lines_t lines,
  input wire logic phase_start,
  input wire itp_pkg::itp_phase_t phase_sel,
  input wire logic idle_check,
  output logic phase_done,
  output logic phase_busy,
  output logic bus_idle,
  output logic micro_tick,
  output logic milli_tick
);
  logic [31:0] live_reg [5];
  logic [31:0] live_next [5];
  logic [31:0] shad_reg [5];
  logic [31:0] shad_next [5];
  logic [31:0] rd_data_reg, rd_data_next;
  logic [15:0] us_cnt_reg, us_cnt_next, ms_cnt_reg, ms_cnt_next;
  logic us_tick_reg, us_tick_next, ms_tick_reg, ms_tick_next;
  itp_pkg::itp_cstate_t cs_reg, cs_next;
  itp_pkg::itp_phase_t sel_reg, sel_next;
  logic [15:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next, done_reg, done_next;
  logic [15:0] q_cnt_reg, q_cnt_next;
  logic idle_reg, idle_next, need_sda_reg, need_sda_next;

  function automatic logic [15:0] fld(input logic [31:0] r, input int lsb);
    fld = r[lsb +: itp_pkg::FLD_W];
  endfunction : fld

  function automatic logic [2:0] reg_index(input logic [7:0] a);
    reg_index = a[4:2];
  endfunction : reg_index

  // Cycle count for each phase, always from the shadow copy
  function automatic logic [15:0] phase_count(input itp_pkg::itp_phase_t p);
    case (p)
      itp_pkg::PH_BEGIN_SETUP: phase_count = fld(shad_reg[1], itp_pkg::LO_LSB);
      itp_pkg::PH_BEGIN_HOLD: phase_count = fld(shad_reg[1], itp_pkg::HI_LSB);
      itp_pkg::PH_END_SETUP: phase_count = fld(shad_reg[2], itp_pkg::LO_LSB);
      itp_pkg::PH_END_HOLD: phase_count = fld(shad_reg[1], itp_pkg::LO_LSB);
      itp_pkg::PH_DATA_SETUP: phase_count = fld(shad_reg[3], itp_pkg::LO_LSB);
      itp_pkg::PH_DATA_HOLD: phase_count = fld(shad_reg[3], itp_pkg::HI_LSB);
      itp_pkg::PH_CLK_HIGH: phase_count = fld(shad_reg[4], itp_pkg::LO_LSB);
      itp_pkg::PH_CLK_LOW: phase_count = fld(shad_reg[4], itp_pkg::HI_LSB);
      default: phase_count = 16'h0000;
    endcase
  endfunction : phase_count

  // Line condition that must hold while a phase counts; a break restarts it
  function automatic logic lines_hold(input itp_pkg::itp_phase_t p, input itp_pkg::itp_lines_t l);
    case (p)
      itp_pkg::PH_BEGIN_SETUP: lines_hold = l.scl & l.sda;
      itp_pkg::PH_END_SETUP: lines_hold = l.scl & ~l.sda;
      default: lines_hold = 1'b1;
    endcase
  endfunction : lines_hold

  localparam logic [31:0] RST_VAL [5] = '{
    {itp_pkg::RST_MILLI_DIV, itp_pkg::RST_MICRO_DIV},
    {itp_pkg::RST_BEGIN_HOLD, itp_pkg::RST_BEGIN_SETUP},
    {itp_pkg::RST_QUIET, itp_pkg::RST_END_SETUP},
    {itp_pkg::RST_DATA_HOLD, itp_pkg::RST_DATA_SETUP},
    {itp_pkg::RST_CLK_LOW, itp_pkg::RST_CLK_HIGH}
  };

  // Register file and shadow copies
  generate
    for (genvar i = 0; i < 5; i++)
    begin : g_regs
      always_comb
      begin
        live_next[i] = live_reg[i];
        if (bus_req.wr && bus_req.addr[1:0] == 2'b00 && bus_req.addr[7:5] == 3'h0 && reg_index(bus_req.addr) == i)
        begin
          live_next[i] = bus_req.wdata;
        end
        shad_next[i] = boot_active ? shad_reg[i] : live_reg[i];
      end
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          live_reg[i] <= RST_VAL[i];
          shad_reg[i] <= RST_VAL[i];
        end
        else if (ce)
        begin
          live_reg[i] <= live_next[i];
          shad_reg[i] <= shad_next[i];
        end
      end
    end
  endgenerate

  always_comb
  begin
    rd_data_next = 32'h0000_0000;
    if (bus_req.rd)
    begin
      if (bus_req.addr == itp_pkg::OFS_STATUS)
      begin
        rd_data_next[itp_pkg::ST_BOOT] = boot_active;
        rd_data_next[itp_pkg::ST_BUSY] = phase_busy;
        rd_data_next[itp_pkg::ST_IDLE] = idle_reg;
        rd_data_next[itp_pkg::ST_QUIET_SDA] = need_sda_reg;
      end
      else if (bus_req.addr[1:0] == 2'b00 && bus_req.addr < itp_pkg::OFS_STATUS)
      begin
        rd_data_next = live_reg[reg_index(bus_req.addr)];
      end
    end
  end

  // Cascaded tick dividers
  always_comb
  begin
    us_cnt_next = us_cnt_reg + 16'h0001;
    us_tick_next = 1'b0;
    ms_cnt_next = ms_cnt_reg;
    ms_tick_next = 1'b0;
    if (us_cnt_reg >= fld(shad_reg[0], itp_pkg::LO_LSB))
    begin
      us_cnt_next = 16'h0000;
      us_tick_next = 1'b1;
    end
    if (us_tick_reg)
    begin
      ms_cnt_next = ms_cnt_reg + 16'h0001;
      if (ms_cnt_reg >= fld(shad_reg[0], itp_pkg::HI_LSB))
      begin
        ms_cnt_next = 16'h0000;
        ms_tick_next = 1'b1;
      end
    end
  end

  // Phase counter
  always_comb
  begin
    cs_next = cs_reg;
    sel_next = sel_reg;
    cnt_next = cnt_reg;
    case (cs_reg)
      itp_pkg::CS_WAIT, itp_pkg::CS_DONE:
      begin
        cs_next = itp_pkg::CS_WAIT;
        if (phase_start)
        begin
          cs_next = itp_pkg::CS_COUNT;
          sel_next = phase_sel;
          cnt_next = phase_count(phase_sel);
        end
      end
      itp_pkg::CS_COUNT:
      begin
        if (sel_reg == itp_pkg::PH_CLK_HIGH && !lines.scl)
        begin
          cs_next = itp_pkg::CS_DONE;
        end
        else if (!lines_hold(sel_reg, lines))
        begin
          cnt_next = phase_count(sel_reg);
        end
        else if (cnt_reg <= 16'h0001)
        begin
          cs_next = itp_pkg::CS_DONE;
        end
        else
        begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      default: cs_next = itp_pkg::CS_WAIT;
    endcase
    // Status outputs come from their own flops
    busy_next = (cs_next == itp_pkg::CS_COUNT);
    done_next = (cs_next == itp_pkg::CS_DONE);
  end

  // Bus quiet detector, in micro ticks
  always_comb
  begin
    q_cnt_next = q_cnt_reg;
    idle_next = idle_reg;
    need_sda_next = need_sda_reg;
    if (idle_check)
    begin
      need_sda_next = 1'b1;
      idle_next = 1'b0;
      q_cnt_next = 16'h0000;
    end
    else if (!(lines.scl && (lines.sda || !need_sda_reg)))
    begin
      idle_next = 1'b0;
      q_cnt_next = 16'h0000;
    end
    else if (fld(shad_reg[2], itp_pkg::HI_LSB) == 16'h0000)
    begin
      idle_next = 1'b1;
    end
    else if (us_tick_reg && !idle_reg)
    begin
      q_cnt_next = q_cnt_reg + 16'h0001;
      if (q_cnt_next >= fld(shad_reg[2], itp_pkg::HI_LSB))
      begin
        idle_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_data_reg <= 32'h0000_0000;
      us_cnt_reg <= 16'h0000;
      ms_cnt_reg <= 16'h0000;
      us_tick_reg <= 1'b0;
      ms_tick_reg <= 1'b0;
      cs_reg <= itp_pkg::CS_WAIT;
      sel_reg <= itp_pkg::PH_BEGIN_SETUP;
      cnt_reg <= 16'h0000;
      q_cnt_reg <= 16'h0000;
      idle_reg <= 1'b0;
      need_sda_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (ce)
    begin
      rd_data_reg <= rd_data_next;
      us_cnt_reg <= us_cnt_next;
      ms_cnt_reg <= ms_cnt_next;
      us_tick_reg <= us_tick_next;
      ms_tick_reg <= ms_tick_next;
      cs_reg <= cs_next;
      sel_reg <= sel_next;
      cnt_reg <= cnt_next;
      q_cnt_reg <= q_cnt_next;
      idle_reg <= idle_next;
      need_sda_reg <= need_sda_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign micro_tick = us_tick_reg;
  assign milli_tick = ms_tick_reg;
  assign phase_done = done_reg;
  assign phase_busy = busy_reg;
  assign bus_idle = idle_reg;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_micro_tick_spacing: assert property (
    (ce && micro_tick && $stable(shad_reg[0]) && fld(shad_reg[0], itp_pkg::LO_LSB) == 16'h0000) |=> micro_tick || !ce)
    else $error("micro tick missing with divider zero");
  a_micro_tick_single: assert property (
    (ce && micro_tick && fld(shad_reg[0], itp_pkg::LO_LSB) != 16'h0000) |=> !micro_tick)
    else $error("micro tick too close");
  a_milli_needs_micro: assert property (
    $rose(milli_tick) |-> $past(micro_tick))
    else $error("milli tick without micro tick");
  a_shadow_frozen: assert property (
    (boot_active && $past(boot_active)) |-> $stable(shad_reg[1]))
    else $error("shadow changed during boot load");
  a_shadow_follows: assert property (
    (ce && !boot_active) |=> shad_reg[3] == $past(live_reg[3]))
    else $error("shadow did not follow register");
  a_begin_setup_break: assert property (
    (ce && phase_busy && sel_reg == itp_pkg::PH_BEGIN_SETUP && !(lines.scl && lines.sda)) |=>
    cnt_reg == phase_count(itp_pkg::PH_BEGIN_SETUP) && !phase_done)
    else $error("start setup not restarted");
  a_end_setup_break: assert property (
    (ce && phase_busy && sel_reg == itp_pkg::PH_END_SETUP && !(lines.scl && !lines.sda)) |=> !phase_done)
    else $error("stop setup ended with wrong lines");
  a_clk_high_short: assert property (
    (ce && phase_busy && sel_reg == itp_pkg::PH_CLK_HIGH && !lines.scl) |=> phase_done)
    else $error("clock high not cut short");
  a_load_count: assert property (
    (ce && phase_start && !phase_busy) |=> phase_busy && cnt_reg == phase_count($past(phase_sel)))
    else $error("phase count not loaded");
  a_quiet_zero: assert property (
    (ce && !idle_check && lines.scl && lines.sda && fld(shad_reg[2], itp_pkg::HI_LSB) == 16'h0000) |=> bus_idle)
    else $error("zero quiet count not idle at once");
  a_idle_drop: assert property (
    (ce && need_sda_reg && !lines.sda) |=> !bus_idle)
    else $error("idle kept with data low");
  a_check_clears: assert property (
    (ce && idle_check) |=> !bus_idle && need_sda_reg)
    else $error("idle check did not restart detect");

  c_phase_done: cover property (phase_busy ##1 phase_done);
  c_clk_high_cut: cover property (phase_busy && sel_reg == itp_pkg::PH_CLK_HIGH ##1 phase_done);
  c_idle_after_check: cover property (idle_check ##[1:200] bus_idle);
  c_milli: cover property (milli_tick);
endmodule : itp_timing

// ---- shared/itp_pkg.sv ----
package itp_pkg;
  localparam logic [7:0] OFS_TICK_DIV = 8'h00;
  localparam logic [7:0] OFS_BEGIN_COND = 8'h04;
  localparam logic [7:0] OFS_END_IDLE = 8'h08;
  localparam logic [7:0] OFS_DATA_SH = 8'h0c;
  localparam logic [7:0] OFS_CLK_HL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 16;
  localparam int FLD_W = 16;
  localparam logic [15:0] RST_MICRO_DIV = 16'h0063;
  localparam logic [15:0] RST_MILLI_DIV = 16'h03e7;
  localparam logic [15:0] RST_BEGIN_SETUP = 16'h01d7;
  localparam logic [15:0] RST_BEGIN_HOLD = 16'h0191;
  localparam logic [15:0] RST_END_SETUP = 16'h0191;
  localparam logic [15:0] RST_QUIET = 16'h0033;
  localparam logic [15:0] RST_DATA_SETUP = 16'h007e;
  localparam logic [15:0] RST_DATA_HOLD = 16'h001f;
  localparam logic [15:0] RST_CLK_HIGH = 16'h01f4;
  localparam logic [15:0] RST_CLK_LOW = 16'h01f4;
  localparam int ST_BOOT = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_IDLE = 2;
  localparam int ST_QUIET_SDA = 3;
  typedef enum logic [2:0]
  {
    PH_BEGIN_SETUP = 3'h0,
    PH_BEGIN_HOLD = 3'h1,
    PH_END_SETUP = 3'h2,
    PH_END_HOLD = 3'h3,
    PH_DATA_SETUP = 3'h4,
    PH_DATA_HOLD = 3'h5,
    PH_CLK_HIGH = 3'h6,
    PH_CLK_LOW = 3'h7
  } itp_phase_t;
  typedef enum logic [1:0]
  {
    CS_WAIT = 2'b00,
    CS_COUNT = 2'b01,
    CS_DONE = 2'b11
  } itp_cstate_t;
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } itp_bus_req_t;
  typedef struct packed
  {
    logic scl;
    logic sda;
  } itp_lines_t;
endpackage : itp_pkg

// ---- testbench/itp_bus_partner.sv ----
`timescale 1ns/1ps
module itp_bus_partner (
  input wire logic clk_sys,
  input wire logic scl_low,
  input wire logic sda_low,
  output itp_pkg::itp_lines_t lines
);
  // Open-drain wires with pull-ups: a released line reads high
  always_ff @(posedge clk_sys)
  begin
    lines <= '{scl: ~scl_low, sda: ~sda_low};
  end
endmodule : itp_bus_partner

// ---- testbench/i2c_bus_timing_prescaler_bench.sv ----
`timescale 1ns/1ps
module i2c_bus_timing_prescaler_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] held;
  itp_pkg::itp_bus_req_t bus_req = '0;
  logic [31:0] rd_data;
  logic boot_active = 1'b0;
  itp_pkg::itp_lines_t lines;
  logic phase_start = 1'b0;
  itp_pkg::itp_phase_t phase_sel = itp_pkg::PH_BEGIN_SETUP;
  logic idle_check = 1'b0;
  logic phase_done, phase_busy, bus_idle, micro_tick, milli_tick;
  logic scl_low = 1'b0;
  logic sda_low = 1'b1;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0 = 0;
  int cnt;
  int k;
  logic rd_pend = 1'b0;
  logic [31:0] exp_rd[$];
  int exp_lat[$];
  logic [31:0] rnd = 32'hc959;
  int ph_n[8] = '{3, 5, 4, 3, 1, 2, 7, 4};
  logic [1:0] ph_ln[8] = '{2'b11, 2'b10, 2'b10, 2'b11, 2'b01, 2'b01, 2'b11, 2'b01};

  always #20 clk_sys = ~clk_sys;

  itp_timing i_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .boot_active(boot_active),
    .lines(lines),
    .phase_start(phase_start),
    .phase_sel(phase_sel),
    .idle_check(idle_check),
    .phase_done(phase_done),
    .phase_busy(phase_busy),
    .bus_idle(bus_idle),
    .micro_tick(micro_tick),
    .milli_tick(milli_tick)
  );

  itp_bus_partner i_far (
    .clk_sys(clk_sys),
    .scl_low(scl_low),
    .sda_low(sda_low),
    .lines(lines)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, '0);
  endtask : rd

  task automatic pulse_idle();
    @(posedge clk_sys);
    idle_check <= 1'b1;
    @(posedge clk_sys);
    idle_check <= 1'b0;
  endtask : pulse_idle

  task automatic run_phase(input int sel, input int n, input logic [1:0] ln);
    @(posedge clk_sys);
    {scl_low, sda_low} <= ~ln;
    repeat (3) @(posedge clk_sys);
    exp_lat.push_back(n + 1);
    phase_sel <= itp_pkg::itp_phase_t'(3'(sel));
    phase_start <= 1'b1;
    @(posedge clk_sys);
    phase_start <= 1'b0;
    cnt = 0;
    do
    begin
      @(negedge clk_sys);
      cnt++;
    end
    while (phase_done !== 1'b1 && cnt < 200);
    chk("phase done seen", 32'(phase_done === 1'b1), 32'h1);
  endtask : run_phase

  // Lines wrong at the start, data line put right six edges in: two reloads before counting
  task automatic break_phase(input int sel, input int n, input logic [1:0] ln, input logic sda_fix);
    fork
      run_phase(sel, n, ln);
      begin
        repeat (6) @(posedge clk_sys);
        sda_low <= sda_fix;
      end
    join
  endtask : break_phase

  // Result watcher: read data one cycle after the strobe, phase latency from the start cycle
  always @(posedge clk_sys) cyc <= cyc + 1;
  always @(negedge clk_sys)
  begin
    if (rd_pend && exp_rd.size() > 0) chk("rd_data", rd_data, exp_rd.pop_front());
    rd_pend = bus_req.rd;
    if (phase_start && phase_busy !== 1'b1) t0 = cyc;
    if (phase_done === 1'b1 && exp_lat.size() > 0) chk("phase", 32'(cyc - t0), 32'(exp_lat.pop_front()));
  end

  initial
  begin
    repeat (12000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // Data line held low: only the clock line may decide idleness here
    repeat (5000) @(negedge clk_sys);
    chk("idle early", bus_idle, 32'h0);
    repeat (300) @(negedge clk_sys);
    chk("idle after reset", bus_idle, 32'h1);
    $display("reset idle test done");
    rd(itp_pkg::OFS_TICK_DIV, 32'h03e70063);
    rd(itp_pkg::OFS_BEGIN_COND, 32'h019101d7);
    rd(itp_pkg::OFS_END_IDLE, 32'h00330191);
    rd(itp_pkg::OFS_DATA_SH, 32'h001f007e);
    rd(itp_pkg::OFS_CLK_HL, 32'h01f401f4);
    rd(8'h18, 32'h0);
    rd(8'h01, 32'h0);
    rnd = lfsr(rnd);
    bus(1'b1, itp_pkg::OFS_CLK_HL, rnd);
    rd(itp_pkg::OFS_CLK_HL, rnd);
    $display("register test done");
    bus(1'b1, itp_pkg::OFS_TICK_DIV, {16'd3, 16'd1});
    bus(1'b1, itp_pkg::OFS_BEGIN_COND, {16'd5, 16'd3});
    bus(1'b1, itp_pkg::OFS_END_IDLE, {16'd3, 16'd4});
    rnd = lfsr(rnd);
    ph_n[4] = int'(rnd[3:0]) + 1;
    bus(1'b1, itp_pkg::OFS_DATA_SH, {16'd2, 16'(ph_n[4])});
    bus(1'b1, itp_pkg::OFS_CLK_HL, {16'd4, 16'd7});
    repeat (10) @(negedge clk_sys);
    cnt = 0;
    k = 0;
    repeat (40)
    begin
      @(negedge clk_sys);
      cnt += int'(micro_tick === 1'b1);
      k += int'(milli_tick === 1'b1);
    end
    chk("micro ticks", 32'(cnt), 32'd20);
    chk("milli ticks", 32'(k), 32'd5);
    @(posedge clk_sys);
    ce <= 1'b0;
    @(negedge clk_sys);
    held = {milli_tick, micro_tick};
    cnt = 0;
    repeat (12)
    begin
      @(negedge clk_sys);
      cnt += int'({milli_tick, micro_tick} !== held);
    end
    chk("frozen ticks", 32'(cnt), 32'd0);
    @(posedge clk_sys);
    ce <= 1'b1;
    $display("tick test done");
    for (int i = 0; i < 8; i++) run_phase(i, ph_n[i], ph_ln[i]);
    break_phase(2, 6, 2'b11, 1'b1);
    break_phase(0, 5, 2'b10, 1'b0);
    run_phase(6, 1, 2'b01);
    $display("phase test done");
    @(posedge clk_sys);
    boot_active <= 1'b1;
    bus(1'b1, itp_pkg::OFS_BEGIN_COND, {16'd5, 16'd9});
    rd(itp_pkg::OFS_BEGIN_COND, {16'd5, 16'd9});
    rd(itp_pkg::OFS_STATUS, 32'h1 << itp_pkg::ST_BOOT);
    run_phase(0, 3, 2'b11);
    @(posedge clk_sys);
    boot_active <= 1'b0;
    run_phase(0, 9, 2'b11);
    $display("boot shadow test done");
    @(posedge clk_sys);
    sda_low <= 1'b1;
    pulse_idle();
    repeat (30) @(negedge clk_sys);
    chk("idle sda low", bus_idle, 32'h0);
    @(posedge clk_sys);
    sda_low <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("idle too soon", bus_idle, 32'h0);
    repeat (10) @(negedge clk_sys);
    chk("idle both high", bus_idle, 32'h1);
    bus(1'b1, itp_pkg::OFS_END_IDLE, {16'd0, 16'd4});
    repeat (2) @(posedge clk_sys);
    pulse_idle();
    repeat (3) @(negedge clk_sys);
    chk("idle zero count", bus_idle, 32'h1);
    $display("idle test done");
    bus(1'b1, itp_pkg::OFS_TICK_DIV, {16'd3, 16'd0});
    repeat (4) @(negedge clk_sys);
    cnt = 0;
    repeat (8)
    begin
      @(negedge clk_sys);
      cnt += int'(micro_tick === 1'b1);
    end
    chk("micro ticks div zero", 32'(cnt), 32'd8);
    $display("divider zero test done");
    repeat (3) @(negedge clk_sys);
    chk("pending results", 32'(exp_rd.size() + exp_lat.size()), 32'h0);
    report_and_stop();
  end
endmodule : i2c_bus_timing_prescaler_bench
